// *** hw/hrt_headroom_rail.sv ***
// headroom tracker attenuation, reporting and class-DG rail selection
//
// Behaviour
// [RULE_01] begin event when attenuation first becomes nonzero
// [RULE_02] end event when attenuation fully released
// [RULE_03] no events for nonzero level changes
// [RULE_04] maximum attenuation setting 1 to 15 dB
// [RULE_05] clamp applied attenuation at maximum setting
// [RULE_06] TDM report: 14-bit linear, 16383 is 0dB
// [RULE_07] inter-chip: two bytes, 10-bit level, six zeros
// [RULE_08] inter-chip count weighs 0.015625 dB
// [RULE_09] report within maximum, zero when inactive
// [RULE_10] attack at selected rate plus 0.5ms/dB
// [RULE_11] release rate plus 3.5ms; 2ms/dB acts 3.5ms/dB
// [RULE_12] supply drop attacks, supply recovery releases
// [RULE_13] hysteresis holds attenuation until rise exceeds level
// [RULE_14] speaker path follows speaker enable bit
// [RULE_15] modulator 320kHz, 620kHz with double bit
// [RULE_16] mode 0 is class-DG rail switching
// [RULE_17] low battery forces PVDD in class-DG
// [RULE_18] threshold method: fixed, headroom, or lower
// [RULE_19] VBAT after hold time, at zero crossing
// [RULE_20] indicator high on VBAT; fast return to PVDD
// [RULE_21] mode 1 fixes PVDD, mode 2 fixes VBAT
// [RULE_22] rate and hysteresis fields use lookup tables
module hrt_headroom_rail
  import hrt_pkg::*;
#(
  parameter int CYC_PER_US = DEF_CYC_PER_US
)
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // attenuation demands from the curve math, 1/64 dB per count
  input  wire logic [ATTEN_W-1:0]   signal_atten_demand,
  input  wire logic [ATTEN_W-1:0]   supply_atten_demand,
  input  wire logic [12:0]          supply_mv,
  // tracker configuration
  input  wire logic [3:0]           max_atten_setting,
  input  wire logic [2:0]           attack_rate_select,
  input  wire logic [2:0]           release_rate_select,
  input  wire logic                 supply_hysteresis_enable,
  input  wire logic [2:0]           supply_hysteresis_level,
  // reporting
  input  wire logic                 tdm_mode,
  input  wire logic                 atten_report_tx_enable,
  input  wire logic                 icc_share_enable,
  input  wire logic                 icc_frame_start,
  // amplifier configuration
  input  wire logic                 speaker_path_enable,
  input  wire logic                 double_switch_freq,
  input  wire logic [1:0]           amp_rail_mode,
  input  wire logic [12:0]          vbat_mv,
  input  wire logic [12:0]          low_battery_level,
  input  wire logic [1:0]           rail_threshold_method,
  input  wire logic [12:0]          battery_relative_headroom,
  input  wire logic [12:0]          fixed_rail_threshold,
  input  wire logic [2:0]           rail_hold_time,
  input  wire logic [12:0]          signal_peak_mv,
  input  wire logic                 zero_cross,
  // tracker outputs
  output logic [ATTEN_W-1:0]        current_atten,
  output logic                      tracker_active,
  output logic                      atten_begin_event,
  output logic                      atten_end_event,
  output logic [13:0]               tdm_atten_word,
  output logic                      tdm_atten_valid,
  output logic [7:0]                icc_slot_hi,
  output logic [7:0]                icc_slot_lo,
  output logic                      icc_slot_valid,
  // amplifier outputs
  output logic                      speaker_path_on,
  output logic                      switch_tick,
  output logic                      double_freq_on,
  output logic [12:0]               rail_switch_threshold,
  output logic                      low_rail_indicator
);

  logic [ATTEN_W-1:0] held_supply;
  logic [12:0]        supply_ref;
  logic [13:0]        release_point;
  logic [ATTEN_W-1:0] raw_target;
  logic [ATTEN_W-1:0] atten_limit;
  logic [ATTEN_W-1:0] atten_target;
  logic [3:0]         max_db;
  logic [31:0]        atk_period;
  logic [31:0]        rls_period;
  logic [31:0]        rls_us;
  logic               atk_tick;
  logic               rls_tick;
  logic               active_d;
  logic [13:0]        gain_hi;
  logic [13:0]        gain_lo;
  logic [16:0]        gain_drop;
  logic [13:0]        gain_now;
  logic [31:0]        sw_period;
  logic [12:0]        headroom_thr;
  logic [12:0]        next_thr;
  logic               force_pvdd;
  logic [31:0]        hold_cyc;
  logic [31:0]        hold_cnt;
  hrt_rail_t          rail;
  hrt_rail_t          next_rail;

  // supply demand with optional hysteresis: deeper demand is taken at once,
  // shallower demand only once the supply rose past the hysteresis amount
  assign release_point = {1'b0, supply_ref} + {1'b0, HYST_MV_LUT[supply_hysteresis_level]};

  always_ff @(posedge mclk) begin
    if (rst) begin
      held_supply <= '0;
      supply_ref  <= 13'h0;
    end else if (supply_atten_demand >= held_supply) begin
      held_supply <= supply_atten_demand;  // see [RULE_12]
      supply_ref  <= supply_mv;
    end else if (!supply_hysteresis_enable || {1'b0, supply_mv} > release_point) begin
      held_supply <= supply_atten_demand;  // see [RULE_13]
      supply_ref  <= supply_mv;
    end
  end

  // target is the deeper demand, clamped at the programmed maximum
  always_comb begin
    if (max_atten_setting < MAX_ATTEN_MIN_DB) begin
      max_db = MAX_ATTEN_MIN_DB;  // see [RULE_04]
    end else if (max_atten_setting > MAX_ATTEN_MAX_DB) begin
      max_db = MAX_ATTEN_MAX_DB;
    end else begin
      max_db = max_atten_setting;
    end
    atten_limit  = {max_db, {FRAC_BITS{1'b0}}};
    raw_target   = (signal_atten_demand > held_supply) ? signal_atten_demand : held_supply;
    atten_target = (raw_target > atten_limit) ? atten_limit : raw_target;  // see [RULE_05]
  end

  // step periods: one count per tick, so ms/dB spread over 64 counts
  assign rls_us     = (release_rate_select == 3'h0) ? PK_RELEASE_US  // see [RULE_11]
                      : RLS_US_LUT[release_rate_select] + PK_RELEASE_US;
  assign atk_period = 32'(((ATK_US_LUT[attack_rate_select] + PK_ATTACK_US_PER_DB)
                      * 32'(CYC_PER_US)) / STEPS_PER_DB);  // see [RULE_10] [RULE_22]
  assign rls_period = 32'((rls_us * 32'(CYC_PER_US)) / STEPS_PER_DB);  // see [RULE_22]

  hrt_tick_gen u_atk_tick (
    .mclk   (mclk),
    .rst    (rst),
    .period (atk_period),
    .tick   (atk_tick)
  );

  hrt_tick_gen u_rls_tick (
    .mclk   (mclk),
    .rst    (rst),
    .period (rls_period),
    .tick   (rls_tick)
  );

  // ballistics: a lowered maximum snaps at once rather than ramping,
  // so the applied level exceeds a lowered limit for one cycle only
  always_ff @(posedge mclk) begin
    if (rst) begin
      current_atten <= '0;
    end else if (current_atten > atten_limit) begin
      current_atten <= atten_limit;  // see [RULE_05] [RULE_09]
    end else if (atk_tick && current_atten < atten_target) begin
      current_atten <= current_atten + 10'h1;  // see [RULE_10] [RULE_12]
    end else if (rls_tick && current_atten > atten_target) begin
      current_atten <= current_atten - 10'h1;  // see [RULE_11] [RULE_12]
    end
  end

  assign tracker_active = (current_atten != '0);

  // events fire only on the zero / nonzero boundary
  always_ff @(posedge mclk) begin
    if (rst) begin
      active_d          <= 1'b0;
      atten_begin_event <= 1'b0;
      atten_end_event   <= 1'b0;
    end else begin
      active_d          <= tracker_active;
      atten_begin_event <= tracker_active && !active_d;  // see [RULE_01] [RULE_03]
      atten_end_event   <= !tracker_active && active_d;  // see [RULE_02] [RULE_03]
    end
  end

  // linear gain: whole-dB table plus linear interpolation on the fraction;
  // interpolation error stays well under one dB step
  assign gain_hi   = GAIN_LUT[current_atten[ATTEN_W-1:FRAC_BITS]];
  assign gain_lo   = GAIN_LUT[{1'b0, current_atten[ATTEN_W-1:FRAC_BITS]} + 5'h1];
  assign gain_drop = 17'((gain_hi - gain_lo) * current_atten[FRAC_BITS-1:0]);
  assign gain_now  = gain_hi - 14'(gain_drop >> FRAC_BITS);

  // tdm report, full scale when inactive
  always_ff @(posedge mclk) begin
    if (rst) begin
      tdm_atten_word  <= TDM_FULL_SCALE;
      tdm_atten_valid <= 1'b0;
    end else begin
      tdm_atten_valid <= tdm_mode && atten_report_tx_enable;  // see [RULE_06]
      tdm_atten_word  <= tracker_active ? gain_now : TDM_FULL_SCALE;  // see [RULE_06] [RULE_09]
    end
  end

  // inter-chip share: target latched per frame, msb slot first
  always_ff @(posedge mclk) begin
    if (rst) begin
      icc_slot_hi    <= 8'h0;
      icc_slot_lo    <= 8'h0;
      icc_slot_valid <= 1'b0;
    end else if (icc_frame_start && icc_share_enable) begin
      // count of 1/64 dB, read as negative dB; see [RULE_08]
      {icc_slot_hi, icc_slot_lo} <= tracker_active ?                   // see [RULE_09]
        {atten_target, {ICC_PAD_BITS{1'b0}}} : 16'h0;                  // see [RULE_07]
      icc_slot_valid <= 1'b1;
    end else if (!icc_share_enable) begin
      icc_slot_valid <= 1'b0;
    end
  end

  // speaker path and switching frequency
  always_ff @(posedge mclk) begin
    if (rst) begin
      speaker_path_on <= 1'b0;
      double_freq_on  <= 1'b0;
    end else begin
      speaker_path_on <= speaker_path_enable;  // see [RULE_14]
      double_freq_on  <= double_switch_freq;   // see [RULE_15]
    end
  end

  // carrier stops while the path is off, saving switching power
  assign sw_period = !speaker_path_on ? 32'h0
                     : (double_freq_on ? FSW2X_CYC : FSW_CYC);  // see [RULE_15]

  hrt_tick_gen u_sw_tick (
    .mclk   (mclk),
    .rst    (rst),
    .period (sw_period),
    .tick   (switch_tick)
  );

  // rail threshold per method; headroom saturates at zero on a flat battery
  always_comb begin
    headroom_thr = (vbat_mv > battery_relative_headroom) ?
                   vbat_mv - battery_relative_headroom : 13'h0;
    case (rail_threshold_method)
      THR_FIXED:    next_thr = fixed_rail_threshold;  // see [RULE_18]
      THR_HEADROOM: next_thr = headroom_thr;
      THR_LOWER:    next_thr = (fixed_rail_threshold < headroom_thr) ?
                               fixed_rail_threshold : headroom_thr;
      default:      next_thr = headroom_thr;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rail_switch_threshold <= 13'h0;
    end else begin
      rail_switch_threshold <= next_thr;
    end
  end

  assign force_pvdd = (vbat_mv < low_battery_level)                   // see [RULE_17]
                      || (signal_peak_mv >= rail_switch_threshold);   // see [RULE_20]
  assign hold_cyc   = 32'(HOLD_US_LUT[rail_hold_time] * 32'(CYC_PER_US));

  // hold timer runs only while on PVDD with a quiet signal
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_cnt <= 32'h0;
    end else if (rail != HRT_RAIL_PVDD || force_pvdd) begin
      hold_cnt <= 32'h0;
    end else if (hold_cnt < hold_cyc) begin
      hold_cnt <= hold_cnt + 32'h1;  // see [RULE_19]
    end
  end

  // rail selection; going up to PVDD is immediate, going down waits in class-DG mode only
  always_comb begin
    next_rail = rail;
    if (amp_rail_mode == AMP_MODE_DG) begin
      case (rail)
        HRT_RAIL_PVDD: begin
          if (!force_pvdd && hold_cnt >= hold_cyc) begin
            next_rail = HRT_RAIL_WAIT_ZC;  // see [RULE_16] [RULE_19]
          end
        end
        HRT_RAIL_WAIT_ZC: begin
          if (force_pvdd) begin
            next_rail = HRT_RAIL_PVDD;
          end else if (zero_cross) begin
            next_rail = HRT_RAIL_VBAT;  // see [RULE_19]
          end
        end
        HRT_RAIL_VBAT: begin
          if (force_pvdd) begin
            next_rail = HRT_RAIL_PVDD;  // see [RULE_17] [RULE_20]
          end
        end
        default: next_rail = HRT_RAIL_PVDD;
      endcase
    end else if (amp_rail_mode == AMP_MODE_VBAT) begin
      next_rail = HRT_RAIL_VBAT;  // see [RULE_21]
    end else begin
      next_rail = HRT_RAIL_PVDD;  // see [RULE_21]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rail               <= HRT_RAIL_PVDD;
      low_rail_indicator <= 1'b0;
    end else begin
      rail               <= next_rail;
      low_rail_indicator <= (next_rail == HRT_RAIL_VBAT);  // see [RULE_20]
    end
  end

endmodule // hrt_headroom_rail

// *** hw/hrt_pkg.sv ***
// constants, tables and types for the headroom attenuator and rail selector
package hrt_pkg;

  // clock and time base
  localparam int CLK_KHZ         = 100000;
  localparam int DEF_CYC_PER_US  = 100;

  // attenuation word: 10 bits, 1/64 dB per count
  localparam int ATTEN_W         = 10;
  localparam int FRAC_BITS       = 6;
  localparam int STEPS_PER_DB    = 64;
  localparam logic [3:0] MAX_ATTEN_MIN_DB = 4'h1;
  localparam logic [3:0] MAX_ATTEN_MAX_DB = 4'hf;

  // peak detector contributions to the ballistics, in microseconds
  localparam logic [31:0] PK_ATTACK_US_PER_DB  = 32'h1f4;   // 0.5 ms/dB
  localparam logic [31:0] PK_RELEASE_US        = 32'hdac;   // 3.5 ms
  localparam logic [31:0] RLS_FASTEST_US       = 32'h7d0;   // 2 ms/dB setting

  // modulator switching frequency
  localparam int FSW_KHZ         = 320;
  localparam int FSW2X_KHZ       = 620;
  localparam logic [31:0] FSW_CYC   = 32'(CLK_KHZ / FSW_KHZ);
  localparam logic [31:0] FSW2X_CYC = 32'(CLK_KHZ / FSW2X_KHZ);

  // reports
  localparam logic [13:0] TDM_FULL_SCALE = 14'h3fff;
  localparam int ICC_PAD_BITS    = 6;

  // amplifier rail modes
  localparam logic [1:0] AMP_MODE_DG   = 2'h0;
  localparam logic [1:0] AMP_MODE_PVDD = 2'h1;
  localparam logic [1:0] AMP_MODE_VBAT = 2'h2;

  // rail threshold methods
  localparam logic [1:0] THR_FIXED    = 2'h0;
  localparam logic [1:0] THR_HEADROOM = 2'h1;
  localparam logic [1:0] THR_LOWER    = 2'h2;

  // programmable tables, indexed by 3-bit select fields
  localparam logic [31:0] ATK_US_LUT [8] = '{32'h32, 32'h64, 32'hc8, 32'h1f4,
                                             32'h3e8, 32'h7d0, 32'h1388, 32'h2710};
  localparam logic [31:0] RLS_US_LUT [8] = '{32'h7d0, 32'h1388, 32'h2710, 32'h4e20,
                                             32'hc350, 32'h186a0, 32'h30d40, 32'h7a120};
  localparam logic [31:0] HOLD_US_LUT [8] = '{32'h0, 32'h3e8, 32'h7d0, 32'h1388,
                                              32'h2710, 32'h4e20, 32'hc350, 32'h186a0};
  localparam logic [12:0] HYST_MV_LUT [8] = '{13'h32, 13'h64, 13'h96, 13'hc8,
                                              13'hfa, 13'h12c, 13'h190, 13'h1f4};

  // linear gain of whole dB steps 0..16, full scale 16383
  localparam logic [13:0] GAIN_LUT [17] = '{14'h3fff, 14'h3909, 14'h32d5, 14'h2d4e,
                                            14'h2861, 14'h23fd, 14'h2013, 14'h1c96,
                                            14'h197a, 14'h16b5, 14'h143d, 14'h1209,
                                            14'h1013, 14'h0e54, 14'h0cc5, 14'h0b61,
                                            14'h0a25};

  typedef enum logic [1:0] {HRT_RAIL_PVDD, HRT_RAIL_WAIT_ZC, HRT_RAIL_VBAT} hrt_rail_t;

endpackage

// *** hw/hrt_tick_gen.sv ***
// free-running tick generator with a programmable period
module hrt_tick_gen
  import hrt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [31:0] period,
  output logic             tick
);

  logic [31:0] count;
  logic [31:0] last;

  // a zero period means stopped, so it never wraps to a huge terminal count
  assign last = (period == 32'h0) ? 32'h0 : period - 32'h1;
  assign tick = (period != 32'h0) && (count >= last);

  // count restarts on the tick; a shortened period takes effect at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= 32'h0;
    end else if (tick || period == 32'h0) begin
      count <= 32'h0;
    end else begin
      count <= count + 32'h1;
    end
  end

endmodule // hrt_tick_gen

// *** verification/hrt_chk_asserts.sv ***
// port assertions for the headroom attenuator and rail selector
module hrt_chk
  import hrt_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic [3:0]         max_atten_setting,
  input wire logic               tdm_mode,
  input wire logic               atten_report_tx_enable,
  input wire logic               icc_share_enable,
  input wire logic               icc_frame_start,
  input wire logic               speaker_path_enable,
  input wire logic [1:0]         amp_rail_mode,
  input wire logic [12:0]        vbat_mv,
  input wire logic [12:0]        low_battery_level,
  input wire logic [1:0]         rail_threshold_method,
  input wire logic [12:0]        fixed_rail_threshold,
  input wire logic [12:0]        rail_switch_threshold,
  input wire logic [ATTEN_W-1:0] current_atten,
  input wire logic               tracker_active,
  input wire logic               atten_begin_event,
  input wire logic               atten_end_event,
  input wire logic [13:0]        tdm_atten_word,
  input wire logic               tdm_atten_valid,
  input wire logic [7:0]         icc_slot_lo,
  input wire logic               icc_slot_valid,
  input wire logic               speaker_path_on,
  input wire logic               low_rail_indicator
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // a setting of 0 behaves as 1 dB
  logic [3:0] max_eff;
  assign max_eff = (max_atten_setting == 4'h0) ? 4'h1 : max_atten_setting;
  sequence s_rise;
    !tracker_active ##1 tracker_active;
  endsequence
  sequence s_fall;
    tracker_active ##1 !tracker_active;
  endsequence

  chk_begin_pulse: assert property (s_rise |=> atten_begin_event)
    else $error("begin event missing");
  chk_end_pulse: assert property (s_fall |=> atten_end_event)
    else $error("end event missing");
  chk_no_mid_event: assert property ((atten_begin_event || atten_end_event)
    |-> $past(tracker_active) != $past(tracker_active, 2)) else $error("stray event");
  chk_max_clamp: assert property ($stable(max_atten_setting)
    |-> current_atten <= {max_eff, 6'h0}) else $error("attenuation above maximum");
  chk_idle_report: assert property (!$past(tracker_active)
    |-> tdm_atten_word == TDM_FULL_SCALE) else $error("idle report not full scale");
  chk_tdm_valid: assert property (!$past(rst)
    |-> tdm_atten_valid == $past(tdm_mode && atten_report_tx_enable)) else $error("tdm valid");
  chk_icc_pad: assert property (icc_frame_start && icc_share_enable
    |=> icc_slot_valid && icc_slot_lo[5:0] == 6'h0) else $error("icc slots");
  chk_speaker_follow: assert property (!$past(rst)
    |-> speaker_path_on == $past(speaker_path_enable)) else $error("speaker path");
  chk_rail_vbat: assert property (amp_rail_mode == AMP_MODE_VBAT
    |=> low_rail_indicator) else $error("fixed vbat rail");
  chk_low_batt: assert property (amp_rail_mode == AMP_MODE_DG
    && vbat_mv < low_battery_level |=> !low_rail_indicator) else $error("low battery rail");
  chk_thr_fixed: assert property (rail_threshold_method == THR_FIXED
    |=> rail_switch_threshold == $past(fixed_rail_threshold)) else $error("fixed threshold");
endmodule  // hrt_chk

// *** verification/hrt_host.sv ***
// host side model: frame starts, zero crossings, shared level decode
module hrt_host
  import hrt_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] icc_slot_hi,
  input  wire logic [7:0] icc_slot_lo,
  output logic            icc_frame_start,
  output logic            zero_cross,
  output logic [9:0]      shared_atten_level
);
  logic [4:0] cnt;

  // free frame counter; one-cycle pulses every 32 cycles, zero crossing half a frame after frame start
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt <= 5'h0;
    end else begin
      cnt <= cnt + 5'h1;
    end
  end
  assign icc_frame_start = (cnt == 5'h1f);
  assign zero_cross      = (cnt == 5'h0f);
  // level is hi byte then top two bits of lo, 1/64 dB a count
  assign shared_atten_level = {icc_slot_hi, icc_slot_lo[7:6]};
endmodule  // hrt_host

// *** verification/tb.sv ***
// self-checking bench for the headroom attenuator and rail selector
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0]  signal_atten_demand, supply_atten_demand, current_atten, shared_atten_level;
  logic [12:0] supply_mv, vbat_mv, low_battery_level, battery_relative_headroom;
  logic [12:0] fixed_rail_threshold, signal_peak_mv, rail_switch_threshold;
  logic [3:0]  max_atten_setting;
  logic [2:0]  attack_rate_select, release_rate_select, supply_hysteresis_level, rail_hold_time;
  logic [1:0]  amp_rail_mode, rail_threshold_method;
  logic [13:0] tdm_atten_word;
  logic [7:0]  icc_slot_hi, icc_slot_lo;
  logic        mclk, rst, supply_hysteresis_enable, tdm_mode, atten_report_tx_enable;
  logic        icc_share_enable, icc_frame_start, speaker_path_enable, double_switch_freq;
  logic        zero_cross, tracker_active, atten_begin_event, atten_end_event, tdm_atten_valid;
  logic        icc_slot_valid, speaker_path_on, switch_tick, double_freq_on, low_rail_indicator;
  logic        zc_d;
  int          error_cnt = 0, num_checks = 0, n_bgn = 0, n_end = 0, g;

  hrt_headroom_rail #(.CYC_PER_US(1)) DUT (.*);
  hrt_host HOST (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // event tally and a delayed zero crossing for the rail timing check
  always @(posedge mclk) begin
    n_bgn += int'(atten_begin_event === 1'b1);
    n_end += int'(atten_end_event === 1'b1);
    zc_d <= zero_cross;
  end

  task automatic cmp(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_atten(logic [9:0] v, int lim);
    while (current_atten !== v && lim > 0) begin
      cyc(1);
      lim--;
    end
    cmp("current_atten", 16'(v), 16'(current_atten));
  endtask
  // cycles between the second and third values of current_atten
  task automatic step_gap(output int n);
    logic [9:0] a;
    for (int k = 0; k < 2; k++) begin
      a = current_atten;
      n = 0;
      while (current_atten === a && n < 300) begin
        cyc(1);
        n++;
      end
    end
  endtask
  task automatic tick_gap(output int n);
    n = 0;
    while (switch_tick !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (switch_tick !== 1'b1 && n < 400);
  endtask

  task automatic t_reset();
    cmp("current_atten", 16'h0, 16'(current_atten));
    cmp("tdm_word", 16'h3fff, 16'(tdm_atten_word));
    cmp("icc_valid", 16'h0, 16'(icc_slot_valid));
    cmp("rail_ind", 16'h0, 16'(low_rail_indicator));
  endtask
  task automatic t_attack();
    @(posedge mclk);
    tdm_mode <= 1'b1;
    atten_report_tx_enable <= 1'b1;
    signal_atten_demand <= 10'h40;
    step_gap(g);
    cmp("attack_gap", 16'h1, 16'(g >= 8 && g <= 9));
    wait_atten(10'h40, 1000);
    cyc(40);
    cmp("begin_cnt", 16'h1, 16'(n_bgn));
    cmp("tdm_word", 16'h3909, 16'(tdm_atten_word));
    cmp("tdm_valid", 16'h1, 16'(tdm_atten_valid));
    cmp("shared_level", 16'h40, 16'(shared_atten_level));
    @(posedge mclk);
    signal_atten_demand <= 10'h80;
    wait_atten(10'h80, 1000);
    cmp("mid_events", 16'h1, 16'(n_bgn + n_end));
  endtask
  task automatic t_clamp();
    @(posedge mclk);
    max_atten_setting <= 4'h3;
    signal_atten_demand <= 10'h3ff;
    wait_atten(10'hc0, 1000);
    cyc(200);
    cmp("clamp_hold", 16'hc0, 16'(current_atten));
    cmp("slot_hi", 16'h30, 16'(icc_slot_hi));
    @(posedge mclk);
    max_atten_setting <= 4'h1;
    cyc(3);
    cmp("clamp_snap", 16'h40, 16'(current_atten));
  endtask
  task automatic t_release();
    @(posedge mclk);
    signal_atten_demand <= 10'h0;
    max_atten_setting <= 4'hf;
    step_gap(g);
    cmp("release_gap", 16'h1, 16'(g >= 54 && g <= 55));
    wait_atten(10'h0, 4000);
    cyc(40);
    cmp("end_cnt", 16'h1, 16'(n_end));
    cmp("tdm_idle", 16'h3fff, 16'(tdm_atten_word));
    cmp("idle_level", 16'h0, 16'(shared_atten_level));
  endtask
  // supply drop held against a small rise, released after a larger one
  task automatic t_hyst();
    @(posedge mclk);
    supply_hysteresis_enable <= 1'b1;
    attack_rate_select <= 3'h1;
    supply_atten_demand <= 10'h20;
    step_gap(g);
    cmp("attack_gap_1", 16'd9, 16'(g));
    wait_atten(10'h20, 600);
    @(posedge mclk);
    supply_atten_demand <= 10'h0;
    supply_mv <= 13'h13a6;
    cyc(300);
    cmp("hyst_hold", 16'h20, 16'(current_atten));
    @(posedge mclk);
    supply_mv <= 13'h13c4;
    release_rate_select <= 3'h1;
    step_gap(g);
    cmp("release_gap_1", 16'd132, 16'(g));
    wait_atten(10'h0, 4500);
  endtask
  task automatic t_rail();
    @(posedge mclk);
    signal_peak_mv <= 13'h0fa0;
    cyc(3);
    cmp("rail_fast", 16'h0, 16'(low_rail_indicator));
    cmp("thr_fixed", 16'h0bb8, 16'(rail_switch_threshold));
    @(posedge mclk);
    signal_peak_mv <= 13'h64;
    g = 0;
    while (low_rail_indicator !== 1'b1 && g < 80) begin
      cyc(1);
      g++;
    end
    cmp("vbat_at_zc", 16'h1, 16'({low_rail_indicator, zc_d} == 2'b11));
    @(posedge mclk);
    vbat_mv <= 13'h09c4;
    cyc(100);
    cmp("low_batt", 16'h0, 16'(low_rail_indicator));
    @(posedge mclk);
    vbat_mv <= 13'h0fa0;
    rail_threshold_method <= 2'h1;
    cyc(3);
    cmp("thr_headroom", 16'h0dac, 16'(rail_switch_threshold));
    @(posedge mclk);
    rail_threshold_method <= 2'h2;
    cyc(3);
    cmp("thr_lower_fix", 16'h0bb8, 16'(rail_switch_threshold));
    @(posedge mclk);
    fixed_rail_threshold <= 13'h0ed8;
    signal_peak_mv <= 13'h0fa0;
    amp_rail_mode <= 2'h2;
    cyc(3);
    cmp("thr_lower_hr", 16'h0dac, 16'(rail_switch_threshold));
    cmp("mode_vbat", 16'h1, 16'(low_rail_indicator));
    @(posedge mclk);
    amp_rail_mode <= 2'h1;
    signal_peak_mv <= 13'h64;
    cyc(40);
    cmp("mode_pvdd", 16'h0, 16'(low_rail_indicator));
  endtask
  task automatic t_switch();
    @(posedge mclk);
    speaker_path_enable <= 1'b1;
    cyc(2);
    cmp("spk_on", 16'h1, 16'(speaker_path_on));
    tick_gap(g);
    cmp("tick_320", 16'd312, 16'(g));
    @(posedge mclk);
    double_switch_freq <= 1'b1;
    tick_gap(g);
    tick_gap(g);
    cmp("dbl_on", 16'h1, 16'(double_freq_on));
    cmp("tick_620", 16'd161, 16'(g));
    @(posedge mclk);
    speaker_path_enable <= 1'b0;
    cyc(2);
    tick_gap(g);
    cmp("tick_off", 16'd400, 16'(g));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog well past the expected run of about 12000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst, supply_hysteresis_enable, tdm_mode, atten_report_tx_enable} = 4'h8;
    {icc_share_enable, speaker_path_enable, double_switch_freq} = 3'h4;
    {signal_atten_demand, supply_atten_demand} = 20'h0;
    {attack_rate_select, release_rate_select, supply_hysteresis_level} = 9'h0;
    {rail_hold_time, amp_rail_mode, rail_threshold_method} = 7'h0;
    {max_atten_setting, supply_mv, vbat_mv} = {4'hf, 13'h1388, 13'h0fa0};
    {low_battery_level, fixed_rail_threshold} = {13'h0bb8, 13'h0bb8};
    {battery_relative_headroom, signal_peak_mv} = {13'h01f4, 13'h0064};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_attack();
    t_clamp();
    t_release();
    t_hyst();
    t_rail();
    t_switch();
    print_verdict();
  end
endmodule  // tb

bind hrt_headroom_rail hrt_chk CHK (.*);
